/* File: rtl/rsa_pkg.sv */
// Package of constants for the rail strobe assignment block
package rsa_pkg;
  localparam logic [7:0] BB_B3_SEQ_ADDR = 8'h23;
  localparam logic [7:0] BACKUP_SEQ_ADDR = 8'h24;
  localparam logic [7:0] SW_REG_SEQ_ADDR = 8'h25;
  localparam logic [7:0] BB_B3_SEQ_RESET = 8'h8a;
  localparam logic [7:0] BACKUP_SEQ_RESET = 8'h12;
  localparam logic [7:0] SW_REG_SEQ_RESET = 8'ha7;
  // Field positions (lsb) within their registers
  localparam int BUCKBOOST_LSB = 4;
  localparam int BUCK3_LSB = 0;
  localparam int BACKUP_1V8_LSB = 4;
  localparam int BACKUP_1V0_LSB = 0;
  localparam int LOWV_SWITCH_LSB = 4;
  localparam int LINREG_LSB = 0;
  // Writable bits of the backup register, reserved bits read zero
  localparam logic [7:0] BACKUP_SEQ_MASK = 8'h33;
  // Strobe range for four-bit fields
  localparam logic [3:0] WIDE_STROBE_MIN = 4'h3;
  localparam logic [3:0] WIDE_STROBE_MAX = 4'ha;
  // Two-bit backup field codes
  localparam logic [1:0] BACKUP_AT_STROBE1 = 2'h1;
  localparam logic [1:0] BACKUP_AT_STROBE2 = 2'h2;
  // Gap timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int GAP_SHORT_MS = 2;
  localparam int GAP_LONG_MS = 5;
  localparam int GAP_SHORT_CYCLES = GAP_SHORT_MS * (CLOCK_HZ / 1000);
  localparam int GAP_LONG_CYCLES = GAP_LONG_MS * (CLOCK_HZ / 1000);
  localparam int GAP_CNT_W = 16;
  typedef enum logic {RSA_GAP_IDLE, RSA_GAP_RUN} rsa_gap_state_t;
endpackage : rsa_pkg

/* File: rtl/rsa_rail_strobe_assignment.sv */
// Rail strobe assignment registers and per-rail enable control
`timescale 1ns/1ps

module rsa_rail_strobe_assignment #(
  parameter int GAP_SHORT = rsa_pkg::GAP_SHORT_CYCLES, // 2 ms in cycles
  parameter int GAP_LONG = rsa_pkg::GAP_LONG_CYCLES    // 5 ms in cycles
) (
  input wire logic clock,                 // 10 MHz clock
  input wire logic srst,                  // Synchronous reset, active high
  input wire logic [7:0] reg_addr,        // Register subaddress
  input wire logic [7:0] reg_wdata,       // Write data
  input wire logic reg_wr,                // Write strobe
  input wire logic reg_unlocked,          // Password scheme satisfied
  output logic [7:0] reg_rdata,           // Read data, one cycle after address
  input wire logic nvm_load,              // Load pulse from nonvolatile store
  input wire logic [7:0] nvm_bb_b3,       // Stored buck-boost/buck3 value
  input wire logic [7:0] nvm_backup,      // Stored backup value
  input wire logic [7:0] nvm_sw_reg,      // Stored switch/regulator value
  input wire logic freshness_seal_flag,   // 1 once the seal is broken
  input wire logic seq_strobe,            // Strobe pulse from the engine
  input wire logic [3:0] seq_index,       // Strobe number 1 to 10
  input wire logic seq_down,              // Strobe belongs to power-down
  input wire logic gap_start,             // Start a gap timer
  input wire logic gap_delay_bit,         // Delay select for this gap
  output logic gap_done,                  // Gap elapsed, one-cycle pulse
  output logic strobe_skipped,            // Strobe 1 or 2 dropped, pulse
  output logic buckboost_rail_en,         // Buck-boost enable
  output logic buck3_rail_en,             // Third buck enable
  output logic backup_1v0_rail_en,        // Backup 1 V enable
  output logic backup_1v8_rail_en,        // Backup 1.8 V enable
  output logic lowv_load_switch_en,       // Low-voltage switch enable
  output logic linear_regulator_en        // Linear regulator enable
);
  import rsa_pkg::*;

  // Stored configuration
  logic [7:0] buckboost_buck3_sequence_reg;
  logic [7:0] backup_rail_sequence_reg;
  logic [7:0] switch_regulator_sequence_reg;

  // Field views
  logic [3:0] buckboost_strobe_select;
  logic [3:0] buck3_strobe_select;
  logic [1:0] backup_1v8_strobe_select;
  logic [1:0] backup_1v0_strobe_select;
  logic [3:0] lowv_switch_strobe_select;
  logic [3:0] linreg_strobe_select;

  // Strobe qualifiers
  logic low_strobe;
  logic strobe_live;
  logic backup_hold;

  // Gap timer
  rsa_gap_state_t gap_state_reg;
  logic [GAP_CNT_W-1:0] gap_cnt_reg;

  function automatic logic wide_hit(input logic [3:0] field, input logic [3:0] idx);
    wide_hit = (field >= WIDE_STROBE_MIN) && (field <= WIDE_STROBE_MAX) && (field == idx);
  endfunction : wide_hit

  function automatic logic backup_hit(input logic [1:0] field, input logic [3:0] idx);
    backup_hit = ((field == BACKUP_AT_STROBE1) || (field == BACKUP_AT_STROBE2))
                 && ({2'h0, field} == idx);
  endfunction : backup_hit

  assign buckboost_strobe_select = buckboost_buck3_sequence_reg[BUCKBOOST_LSB +: 4];
  assign buck3_strobe_select = buckboost_buck3_sequence_reg[BUCK3_LSB +: 4];

  assign backup_1v8_strobe_select = backup_rail_sequence_reg[BACKUP_1V8_LSB +: 2];
  assign backup_1v0_strobe_select = backup_rail_sequence_reg[BACKUP_1V0_LSB +: 2];

  assign lowv_switch_strobe_select = switch_regulator_sequence_reg[LOWV_SWITCH_LSB +: 4];
  assign linreg_strobe_select = switch_regulator_sequence_reg[LINREG_LSB +: 4];

  // seal gates strobes 1 and 2
  assign low_strobe = (seq_index == 4'h1) || (seq_index == 4'h2);
  assign strobe_live = seq_strobe && !(low_strobe && freshness_seal_flag);

  // backup rails stay on after seal
  assign backup_hold = seq_down && freshness_seal_flag;

  always_ff @(posedge clock) begin
    if (srst) begin
      buckboost_buck3_sequence_reg <= BB_B3_SEQ_RESET;
      backup_rail_sequence_reg <= BACKUP_SEQ_RESET;
      switch_regulator_sequence_reg <= SW_REG_SEQ_RESET;
    end else if (nvm_load) begin
      // Stored image wins over a same-cycle bus write
      buckboost_buck3_sequence_reg <= nvm_bb_b3;
      backup_rail_sequence_reg <= nvm_backup & BACKUP_SEQ_MASK;
      switch_regulator_sequence_reg <= nvm_sw_reg;
    end else if (reg_wr && reg_unlocked) begin
      if (reg_addr == BB_B3_SEQ_ADDR) begin
        buckboost_buck3_sequence_reg <= reg_wdata;
      end
      if (reg_addr == BACKUP_SEQ_ADDR) begin
        backup_rail_sequence_reg <= reg_wdata & BACKUP_SEQ_MASK;
      end
      if (reg_addr == SW_REG_SEQ_ADDR) begin
        switch_regulator_sequence_reg <= reg_wdata;
      end
    end
  end

  // Registered read, unmapped reads zero
  // Data trails the address by one cycle, never by zero
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        BB_B3_SEQ_ADDR: reg_rdata <= buckboost_buck3_sequence_reg;
        BACKUP_SEQ_ADDR: reg_rdata <= backup_rail_sequence_reg;
        SW_REG_SEQ_ADDR: reg_rdata <= switch_regulator_sequence_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // wide rails follow their strobe, up sets and down clears
  // Out-of-range field never matches, so the rail keeps its state
  always_ff @(posedge clock) begin
    if (srst) begin
      buckboost_rail_en <= 1'b0;
      buck3_rail_en <= 1'b0;
      lowv_load_switch_en <= 1'b0;
      linear_regulator_en <= 1'b0;
    end else if (strobe_live) begin
      if (wide_hit(buckboost_strobe_select, seq_index)) begin
        buckboost_rail_en <= !seq_down;
      end
      if (wide_hit(buck3_strobe_select, seq_index)) begin
        buck3_rail_en <= !seq_down;
      end
      if (wide_hit(lowv_switch_strobe_select, seq_index)) begin
        lowv_load_switch_en <= !seq_down;
      end
      if (wide_hit(linreg_strobe_select, seq_index)) begin
        linear_regulator_en <= !seq_down;
      end
    end
  end

  // backup rails
  // Down strobes ignored once sealed, keeping the backup domain alive
  always_ff @(posedge clock) begin
    if (srst) begin
      backup_1v0_rail_en <= 1'b0;
      backup_1v8_rail_en <= 1'b0;
    end else if (strobe_live && !backup_hold) begin
      if (backup_hit(backup_1v0_strobe_select, seq_index)) begin
        backup_1v0_rail_en <= !seq_down;
      end
      if (backup_hit(backup_1v8_strobe_select, seq_index)) begin
        backup_1v8_rail_en <= !seq_down;
      end
    end
  end

  // report a dropped low strobe
  // Lets the engine move on without waiting for a rail
  always_ff @(posedge clock) begin
    if (srst) begin
      strobe_skipped <= 1'b0;
    end else begin
      strobe_skipped <= seq_strobe && low_strobe && freshness_seal_flag;
    end
  end

  // gap timer, delay bit sampled at start
  // A start while running is ignored, so a gap cannot be stretched
  // Count loads N-1 so gap_done lands N cycles after the start edge
  always_ff @(posedge clock) begin
    if (srst) begin
      gap_state_reg <= RSA_GAP_IDLE;
      gap_cnt_reg <= '0;
      gap_done <= 1'b0;
    end else begin
      gap_done <= 1'b0;
      unique case (gap_state_reg)
        RSA_GAP_IDLE: begin
          if (gap_start) begin
            gap_state_reg <= RSA_GAP_RUN;
            gap_cnt_reg <= gap_delay_bit ? GAP_CNT_W'(GAP_LONG - 1)
                                         : GAP_CNT_W'(GAP_SHORT - 1);
          end
        end
        RSA_GAP_RUN: begin
          if (gap_cnt_reg == '0) begin
            gap_state_reg <= RSA_GAP_IDLE;
            gap_done <= 1'b1;
          end else begin
            gap_cnt_reg <= gap_cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end
endmodule : rsa_rail_strobe_assignment

/* File: verification/rsa_chk.sv */
// Assertion checker for the rail strobe assignment block
`timescale 1ns/1ps
module rsa_chk (
  input wire logic clock, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] reg_addr, // Subaddress
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic freshness_seal_flag, // Seal broken
  input wire logic seq_strobe, // Strobe pulse
  input wire logic [3:0] seq_index, // Strobe number
  input wire logic gap_done, // Gap end
  input wire logic strobe_skipped, // Dropped strobe
  input wire logic buckboost_rail_en, // Rail
  input wire logic buck3_rail_en, // Rail
  input wire logic backup_1v0_rail_en, // Rail
  input wire logic backup_1v8_rail_en, // Rail
  input wire logic lowv_load_switch_en, // Rail
  input wire logic linear_regulator_en // Rail
);
  logic [5:0] en;
  assign en = {buckboost_rail_en, buck3_rail_en, backup_1v0_rail_en, backup_1v8_rail_en,
    lowv_load_switch_en, linear_regulator_en};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  rst_clear_a: assert property (disable iff (1'b0) srst |=> en == 6'h0 && !gap_done)
    else $error("outputs not cleared by reset");
  idle_hold_a: assert property (!seq_strobe |=> $stable(en))
    else $error("rail changed without strobe");
  wide_range_a: assert property (seq_strobe && (seq_index < 4'h3 || seq_index > 4'ha)
    |=> $stable(en[5:4]) && $stable(en[1:0])) else $error("wide rail moved off range");
  backup_idx_a: assert property (seq_strobe && !(seq_index inside {4'h1, 4'h2})
    |=> $stable(en[3:2])) else $error("backup rail moved off strobe 1 or 2");
  seal_skip_a: assert property (seq_strobe && seq_index inside {4'h1, 4'h2}
    && freshness_seal_flag |=> strobe_skipped && $stable(en)) else $error("strobe not skipped");
  skip_cause_a: assert property (!seq_strobe |=> !strobe_skipped)
    else $error("skip without strobe");
  seal_keep_a: assert property (freshness_seal_flag
    |=> (en[3:2] & $past(en[3:2])) == $past(en[3:2])) else $error("backup rail dropped");
  unmapped_zero_a: assert property (!(reg_addr inside {8'h23, 8'h24, 8'h25})
    |=> reg_rdata == 8'h0) else $error("unmapped read not zero");
  reserved_zero_a: assert property (reg_addr == 8'h24
    |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0) else $error("reserved bits set");
  gap_pulse_a: assert property (gap_done |=> !gap_done)
    else $error("gap end longer than a cycle");
  cover property (strobe_skipped);
  cover property (gap_done);
  cover property ($rose(backup_1v8_rail_en));
endmodule : rsa_chk
bind rsa_rail_strobe_assignment rsa_chk rsa_chk_i (.*);

/* File: verification/rail_strobe_assignment_test.sv */
// Self-checking bench for the rail strobe assignment block
`timescale 1ns/1ps
module rail_strobe_assignment_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0, reg_unlocked = 1'b0, nvm_load = 1'b0, freshness_seal_flag = 1'b0;
  logic seq_strobe = 1'b0, seq_down = 1'b0, gap_start = 1'b0, gap_delay_bit = 1'b0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, nvm_bb_b3 = 8'h0, nvm_backup = 8'h0;
  logic [7:0] nvm_sw_reg = 8'h0, reg_rdata;
  logic [3:0] seq_index = 4'h0;
  logic gap_done, strobe_skipped, bb, b3, b10, b18, ls, lr;
  logic [5:0] me;
  int fail_count = 0, n_tests = 0, k;
  int m[3];
  always #50 clock = ~clock;
  rsa_rail_strobe_assignment #(.GAP_SHORT(4), .GAP_LONG(10)) rsa_rail_strobe_assignment_i (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_unlocked(reg_unlocked), .reg_rdata(reg_rdata), .nvm_load(nvm_load),
    .nvm_bb_b3(nvm_bb_b3), .nvm_backup(nvm_backup), .nvm_sw_reg(nvm_sw_reg),
    .freshness_seal_flag(freshness_seal_flag), .seq_strobe(seq_strobe), .seq_index(seq_index),
    .seq_down(seq_down), .gap_start(gap_start), .gap_delay_bit(gap_delay_bit),
    .gap_done(gap_done), .strobe_skipped(strobe_skipped), .buckboost_rail_en(bb),
    .buck3_rail_en(b3), .backup_1v0_rail_en(b10), .backup_1v8_rail_en(b18),
    .lowv_load_switch_en(ls), .linear_regulator_en(lr));
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d, logic u);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    reg_unlocked = u;
    tick();
    reg_wr = 1'b0;
    if (u && a > 8'h22 && a < 8'h26) m[a - 8'h23] = (a == 8'h24) ? d & 8'h33 : d;
    // Idle cycle so a following write never re-raises the strobe in this time step
    tick();
  endtask : wr
  task automatic rd(logic [7:0] a);
    reg_addr = a;
    tick();
    chk("reg_rdata", reg_rdata, (a > 8'h22 && a < 8'h26) ? 8'(m[a - 8'h23]) : 8'h0);
  endtask : rd
  // Field of rail r, ordered as the enable vector
  function automatic int fld(int r);
    return (m[r / 2] >> ((r == 0 || r == 3 || r == 4) ? 4 : 0)) & ((r == 2 || r == 3) ? 3 : 15);
  endfunction : fld
  task automatic st(int idx, logic dn);
    logic skp;
    skp = (idx == 1 || idx == 2) && freshness_seal_flag;
    for (int r = 0; r < 6; r++)
      if (!skp && fld(r) == idx && ((r == 2 || r == 3) ? (idx == 1 || idx == 2) : idx > 2
          && idx < 11) && !(dn && freshness_seal_flag && (r == 2 || r == 3))) me[5 - r] = !dn;
    seq_strobe = 1'b1;
    seq_index = 4'(idx);
    seq_down = dn;
    tick();
    seq_strobe = 1'b0;
    chk("rail enables", {2'h0, bb, b3, b10, b18, ls, lr}, {2'h0, me});
    chk("strobe_skipped", {7'h0, strobe_skipped}, {7'h0, skp});
    // Idle cycle so the next strobe is not raised in the time step it fell
    tick();
  endtask : st
  task automatic gap(logic b, int n);
    gap_start = 1'b1;
    gap_delay_bit = b;
    tick();
    gap_start = 1'b0;
    k = 0;
    while (gap_done !== 1'b1 && k < 30) begin
      tick();
      k++;
    end
    if (k == 30) begin
      fail_count++;
      summarize();
    end else begin
      chk("gap length", 8'(k), 8'(n));
    end
  endtask : gap
  initial begin
    void'($urandom(32'h2388));
    m = '{8'h8a, 8'h12, 8'ha7};
    me = 6'h0;
    repeat (6) tick();
    srst = 1'b0;
    foreach (m[i]) rd(8'h23 + 8'(i));
    rd(8'h30);
    wr(8'h25, 8'h00, 1'b0);
    wr(8'h24, 8'hff, 1'b1);
    foreach (m[i]) rd(8'h23 + 8'(i));
    $display("register test done");
    for (int j = 0; j < 16; j++) begin
      if (j % 2) begin
        nvm_bb_b3 = {4'(j), 4'(15 - j)};
        nvm_backup = 8'($urandom);
        nvm_sw_reg = 8'($urandom);
        nvm_load = 1'b1;
        tick();
        nvm_load = 1'b0;
        m = '{nvm_bb_b3, nvm_backup & 8'h33, nvm_sw_reg};
      end else begin
        wr(8'h23, {4'(15 - j), 4'(j)}, 1'b1);
        wr(8'h24, 8'($urandom), 1'b1);
        wr(8'h25, 8'($urandom), 1'b1);
      end
      foreach (m[i]) rd(8'h23 + 8'(i));
      for (int s = 0; s < 48; s++) begin
        freshness_seal_flag = (s / 16 == 1);
        st(s % 16, s > 15);
      end
    end
    $display("strobe test done");
    gap(1'b0, 4);
    gap(1'b1, 10);
    $display("gap test done");
    summarize();
  end
endmodule : rail_strobe_assignment_test
